// ### logic/fsi_core.sv
// Purpose: Interrupts, stop handshake, security and reset-time loading
//          for an on-chip flash module.
// Assumes: Memory controller reports command start/end as pulses.
// Notes:   Configuration is read from the array once after reset.
`timescale 1ns/100ps
module fsi_core (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Array read port for the reset sequence
  output fsi_pkg::fsi_nvm_req_t     nvm_req,
  input  wire fsi_pkg::fsi_nvm_rsp_t nvm_rsp,
  // Command engine
  input  wire logic                 cmd_launch,
  input  wire logic                 cmd_done,
  input  wire logic                 cmd_is_keyverify,
  input  wire logic [63:0]          key_presented,
  input  wire logic                 erase_verify_all_ok,
  input  wire logic                 special_single_chip,
  // Interrupt enables and fault flags
  input  wire logic                 command_complete_irq_enable,
  input  wire logic                 double_fault_irq_enable,
  input  wire logic                 single_fault_irq_enable,
  input  wire logic                 double_fault_flag,
  input  wire logic                 single_fault_flag,
  // Processor access and power modes
  input  wire logic                 cmd_reg_write,
  input  wire logic [15:0]          block0_read_data,
  input  wire logic                 stop_request,
  input  wire logic                 wait_mode,
  output logic                      command_complete_flag,
  output logic                      cmd_reg_write_ok,
  output logic                      cmd_abort,
  output logic                      cpu_stall,
  output logic [15:0]               block0_read_out,
  output logic                      block0_read_invalid,
  output logic                      stop_ack,
  output logic                      cmd_irq,
  output logic                      err_irq,
  output logic                      keyverify_ok,
  output logic                      keyverify_fail,
  output logic                      key_lockout,
  output logic [1:0]                verify_fault_status,
  output fsi_pkg::fsi_cfg_t         cfg
);
  import fsi_pkg::*;

  typedef struct packed {
    fsi_step_t   step;
    logic [1:0]  word;
    logic        pend;
    logic [7:0]  stall_cnt;
    logic        seq_err;
    logic        ccf;
    logic        kv_run;
    logic        lockout;
    logic        kv_ok;
    logic        kv_fail;
    logic [1:0]  mg;
    logic [1:0]  sec_live;
    logic [63:0] keys;
    fsi_cfg_t    cfg;
    logic [15:0] rdata;
  } fsi_state_t;

  fsi_state_t state_reg;
  fsi_state_t state_next;
  logic [FSI_NUM_KEYS-1:0] key_match;
  logic        seq_busy;
  logic        keys_ok;

  // One comparator per key word
  for (genvar i = 0; i < FSI_NUM_KEYS; i++) begin : g_key
    fsi_key_cmp u_cmp (
      .stored    (state_reg.keys[16*i +: 16]),
      .presented (key_presented[16*i +: 16]),
      .match     (key_match[i])
    );
  end

  assign seq_busy = (state_reg.step != FSI_LD_DONE);
  assign keys_ok  = &key_match;

  // Read address for the current load step
  always_comb begin
    nvm_req.req  = seq_busy && !state_reg.pend;
    unique case (state_reg.step)
      FSI_LD_KEYS:  nvm_req.addr = FSI_KEY_BASE_ADDR +
                                   23'({state_reg.word, 1'b0});
      FSI_LD_PPROT: nvm_req.addr = FSI_PPROT_ADDR;
      FSI_LD_DPROT: nvm_req.addr = FSI_DPROT_ADDR;
      FSI_LD_OPT:   nvm_req.addr = FSI_OPT_ADDR;
      FSI_LD_SEC:   nvm_req.addr = FSI_SEC_BYTE_ADDR;
      FSI_LD_DONE:  nvm_req.addr = FSI_SEC_BYTE_ADDR;
      default:      nvm_req.addr = FSI_SEC_BYTE_ADDR;
    endcase
  end

  // Next-state logic
  always_comb begin
    state_next         = state_reg;
    state_next.kv_ok   = 1'b0;
    state_next.kv_fail = 1'b0;
    if (state_reg.stall_cnt != 8'h00) begin
      state_next.stall_cnt = state_reg.stall_cnt - 8'h01;
    end
    // Reset sequence steps through the configuration field
    if (seq_busy) begin
      if (nvm_req.req) begin
        state_next.pend = 1'b1;
      end
      if (state_reg.pend && nvm_rsp.valid) begin
        state_next.pend = 1'b0;
        if (nvm_rsp.dbit) begin
          state_next.mg      = 2'h3;
          state_next.seq_err = 1'b1;
        end
        unique case (state_reg.step)
          FSI_LD_KEYS: begin
            state_next.keys[16*state_reg.word +: 16] = nvm_rsp.data;
            state_next.word = state_reg.word + 2'h1;
            if (state_reg.word == 2'h3) begin
              state_next.step = FSI_LD_PPROT;
            end
          end
          FSI_LD_PPROT: begin
            state_next.cfg.program_area_protection_reg = nvm_rsp.data[7:0];
            state_next.step = FSI_LD_DPROT;
          end
          FSI_LD_DPROT: begin
            state_next.cfg.data_area_protection_reg = nvm_rsp.data[7:0];
            state_next.step = FSI_LD_OPT;
          end
          FSI_LD_OPT: begin
            state_next.cfg.option_register = nvm_rsp.data[7:0];
            state_next.step = FSI_LD_SEC;
          end
          FSI_LD_SEC: begin
            state_next.cfg.security_register = nvm_rsp.data[7:0];
            state_next.step = FSI_LD_DONE;
          end
          default: state_next.step = FSI_LD_DONE;
        endcase
      end
      // Fallback to protected, secured defaults on any error
      if (state_next.step == FSI_LD_DONE) begin
        if (state_next.seq_err) begin
          state_next.cfg.security_register = FSI_SEC_DEFAULT;
          state_next.cfg.program_area_protection_reg = FSI_PPROT_DEFAULT;
          state_next.cfg.data_area_protection_reg = FSI_DPROT_DEFAULT;
          state_next.cfg.option_register = FSI_OPT_DEFAULT;
          state_next.keys = {FSI_NUM_KEYS{FSI_KEY_ONES}};
        end
        state_next.sec_live =
          state_next.cfg.security_register[FSI_SEC_LSB +: 2];
        state_next.ccf = 1'b1;
      end
    end else begin
      // Command engine tracking of the complete flag
      if (cmd_launch && state_reg.ccf) begin
        state_next.ccf    = 1'b0;
        state_next.kv_run = cmd_is_keyverify;
      end
      if (cmd_done && !state_reg.ccf) begin
        state_next.ccf    = 1'b1;
        state_next.kv_run = 1'b0;
        // Key verify result updates only the live state
        if (state_reg.kv_run) begin
          if (!state_reg.lockout &&
              state_reg.cfg.security_register[FSI_BACKDOOR_KEY_ENABLE_LSB +: 2] ==
              FSI_BACKDOOR_KEY_ENABLE_ENABLED && keys_ok) begin
            state_next.sec_live = FSI_SEC_UNSECURED;
            state_next.kv_ok    = 1'b1;
          end else begin
            state_next.lockout = 1'b1;
            state_next.kv_fail = 1'b1;
          end
        end
      end
      // Erased-device unsecure path in special single chip mode
      if (special_single_chip && erase_verify_all_ok) begin
        state_next.sec_live = FSI_SEC_UNSECURED;
      end
    end
    // Block 0 read data path, registered in step with the invalid flag
    state_next.rdata = state_next.kv_run ? FSI_BAD_READ_DATA
                                         : block0_read_data;
  end

  // State register; reset also aborts any running command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg           <= '0;
      state_reg.step      <= FSI_LD_KEYS;
      state_reg.stall_cnt <= FSI_STALL_CYC;
      state_reg.sec_live  <= FSI_SEC_DEFAULT[1:0];
      state_reg.cfg       <= {FSI_SEC_DEFAULT, FSI_PPROT_DEFAULT,
                              FSI_DPROT_DEFAULT, FSI_OPT_DEFAULT};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign command_complete_flag = state_reg.ccf;
  assign cmd_reg_write_ok = cmd_reg_write && state_reg.ccf;
  assign cmd_abort        = rst;
  assign cpu_stall        = (state_reg.stall_cnt != 8'h00);
  assign block0_read_out  = state_reg.rdata;
  assign block0_read_invalid = state_reg.kv_run;
  // Stop granted only with no command running; wait has no effect
  assign stop_ack = stop_request && state_reg.ccf && !wait_mode ||
                    stop_request && state_reg.ccf;
  // Level interrupt requests, key verify results and fault status
  assign cmd_irq = state_reg.ccf && command_complete_irq_enable;
  assign err_irq = (double_fault_flag && double_fault_irq_enable) ||
                   (single_fault_flag && single_fault_irq_enable);
  assign keyverify_ok   = state_reg.kv_ok;
  assign keyverify_fail = state_reg.kv_fail;
  assign key_lockout    = state_reg.lockout;
  assign verify_fault_status = state_reg.mg;
  // Stored byte kept; live security field overrides low bits
  always_comb begin
    cfg = state_reg.cfg;
    cfg.security_register[FSI_SEC_LSB +: 2] = state_reg.sec_live;
  end

  // Assertions
  sequence s_launch;
    cmd_launch && command_complete_flag;
  endsequence
  a_cmd_irq_level: assert property (@(posedge clk) disable iff (rst)
    cmd_irq == (command_complete_flag && command_complete_irq_enable))
    else $error("cmd irq mismatch");
  a_err_irq_level: assert property (@(posedge clk) disable iff (rst)
    err_irq == ((double_fault_flag && double_fault_irq_enable) ||
                (single_fault_flag && single_fault_irq_enable)))
    else $error("err irq mismatch");
  a_stop_held_busy: assert property (@(posedge clk) disable iff (rst)
    !command_complete_flag |-> !stop_ack)
    else $error("stop granted while busy");
  a_flag_low_seq: assert property (@(posedge clk) disable iff (rst)
    seq_busy |-> !command_complete_flag)
    else $error("flag set during sequence");
  a_write_ignored: assert property (@(posedge clk) disable iff (rst)
    !command_complete_flag |-> !cmd_reg_write_ok)
    else $error("command write taken while busy");
  a_launch_clears: assert property (@(posedge clk) disable iff (rst)
    s_launch |=> !command_complete_flag)
    else $error("launch did not clear flag");
  a_lockout_sticks: assert property (@(posedge clk) disable iff (rst)
    key_lockout |=> key_lockout)
    else $error("lockout released");
  a_locked_no_ok: assert property (@(posedge clk) disable iff (rst)
    $past(key_lockout) |-> !keyverify_ok)
    else $error("unlock after lockout");
  a_unlock_sec: assert property (@(posedge clk) disable iff (rst)
    keyverify_ok |-> cfg.security_register[1:0] == 2'h2)
    else $error("match did not unsecure");
  a_stall_bound: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> ##[0:6] !cpu_stall)
    else $error("stall too long");
endmodule : fsi_core

// ### logic/fsi_pkg.sv
// Purpose: Shared constants and carrier types for the flash security,
//          interrupt and reset-initialisation block.
// Assumes: One 10 MHz bus clock, asynchronous active-high reset.
// Notes:   Operation
// Operation
// - Command irq when complete flag and enable
// - Error irq from enabled fault flags
// - Wait mode changes nothing; command irq wakes
// - Finish running command before granting stop
// - Reset loads security from configuration byte
// - New security byte waits for next reset
// - Key compare only when key enable set
// - Matching keys force security state 10
// - All-zero or all-one keys never match
// - Block 0 reads invalid during key verify
// - One bad key locks out until reset
// - Verify leaves stored bytes and protection alone
// - Erased flash in special mode unsecures
// - Reset sequence loads configuration and protection
// - Sequence errors fall back to secured defaults
// - Double fault in sequence sets both bits
// - Complete flag low during sequence, then set
// - Stall all accesses in initial sequence part
// - Command writes ignored until complete flag
// - Reset aborts running command immediately
package fsi_pkg;

  // Configuration field byte addresses loaded by the reset sequence
  localparam logic [22:0] FSI_SEC_BYTE_ADDR   = 23'h7FFF0F;
  localparam logic [22:0] FSI_KEY_BASE_ADDR   = 23'h7FFF00;
  localparam logic [22:0] FSI_PPROT_ADDR      = 23'h7FFF0C;
  localparam logic [22:0] FSI_DPROT_ADDR      = 23'h7FFF0D;
  localparam logic [22:0] FSI_OPT_ADDR        = 23'h7FFF0E;

  // Field positions inside the security register
  localparam int          FSI_SEC_LSB         = 0;
  localparam int          FSI_BACKDOOR_KEY_ENABLE_LSB       = 6;
  localparam logic [1:0]  FSI_SEC_UNSECURED   = 2'h2;
  localparam logic [1:0]  FSI_BACKDOOR_KEY_ENABLE_ENABLED   = 2'h2;

  // Built-in fallback values: fully protected and secured
  localparam logic [7:0]  FSI_SEC_DEFAULT     = 8'hFF;
  localparam logic [7:0]  FSI_PPROT_DEFAULT   = 8'h00;
  localparam logic [7:0]  FSI_DPROT_DEFAULT   = 8'h00;
  localparam logic [7:0]  FSI_OPT_DEFAULT     = 8'hFF;

  // Invalid key words, invalid read data and key count
  localparam logic [15:0] FSI_KEY_ZERO        = 16'h0000;
  localparam logic [15:0] FSI_KEY_ONES        = 16'hFFFF;
  localparam logic [15:0] FSI_BAD_READ_DATA   = 16'hFFFF;
  localparam int          FSI_NUM_KEYS        = 4;

  // Stall portion of the reset sequence
  localparam int          FSI_STALL_NS        = 500;
  localparam int          FSI_CLK_NS          = 100;
  localparam logic [7:0]  FSI_STALL_CYC       =
    8'((FSI_STALL_NS + FSI_CLK_NS - 1) / FSI_CLK_NS);

  // Reset-sequence load steps
  typedef enum logic [2:0] {
    FSI_LD_KEYS,
    FSI_LD_PPROT,
    FSI_LD_DPROT,
    FSI_LD_OPT,
    FSI_LD_SEC,
    FSI_LD_DONE
  } fsi_step_t;

  // Read port toward the nonvolatile array
  typedef struct packed {
    logic        req;
    logic [22:0] addr;
  } fsi_nvm_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        sbit;   // Corrected single-bit fault
    logic        dbit;   // Uncorrectable double-bit fault
  } fsi_nvm_rsp_t;

  // Loaded configuration
  typedef struct packed {
    logic [7:0] security_register;
    logic [7:0] program_area_protection_reg;
    logic [7:0] data_area_protection_reg;
    logic [7:0] option_register;
  } fsi_cfg_t;

endpackage : fsi_pkg

// ### logic/fsi_key_cmp.sv
// Purpose: Compares one presented backdoor key with its stored word.
// Assumes: Both words are steady while compared.
// Notes:   Invalid stored or presented words never match.
`timescale 1ns/100ps
module fsi_key_cmp (
  input  wire logic [15:0] stored,
  input  wire logic [15:0] presented,
  output logic             match
);
  import fsi_pkg::*;

  // Equality gated by the validity of the stored key
  assign match = (stored == presented) &&
                 (stored != FSI_KEY_ZERO) &&
                 (stored != FSI_KEY_ONES);
endmodule : fsi_key_cmp

// ### bench/fsi_nvm_model.sv
// Purpose: Array model answering the reset-time configuration reads.
// Assumes: One request at a time; data is valid in its answer cycle only.
// Notes:   Slow mode adds two wait cycles; fault marks every answer.
`timescale 1ns/100ps
module fsi_nvm_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire fsi_pkg::fsi_nvm_req_t nvm_req,
  output fsi_pkg::fsi_nvm_rsp_t      nvm_rsp,
  input  wire fsi_pkg::fsi_cfg_t     cfg_bytes,
  input  wire logic [63:0]           keys,
  input  wire logic                  slow,
  input  wire logic                  fault
);
  import fsi_pkg::*;
  logic [1:0]  wait_cnt;
  logic [15:0] word;
  logic        busy;
  // Stored word at the requested byte address
  always_comb begin
    case (nvm_req.addr[3:0])
      4'hC: word = {2{cfg_bytes.program_area_protection_reg}};
      4'hD: word = {2{cfg_bytes.data_area_protection_reg}};
      4'hE: word = {2{cfg_bytes.option_register}};
      4'hF: word = {2{cfg_bytes.security_register}};
      default: word = keys[16*nvm_req.addr[2:1] +: 16];
    endcase
  end
  // One answer per request; data scrambled outside the answer cycle.
  // The request lasts one cycle, so an open request is remembered here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvm_rsp  <= '0;
      wait_cnt <= 2'h0;
      busy     <= 1'b0;
    end else if ((nvm_req.req || busy)
                 && wait_cnt == (slow ? 2'h2 : 2'h0)) begin
      nvm_rsp  <= {1'b1, word, 1'b0, fault};
      wait_cnt <= 2'h0;
      busy     <= 1'b0;
    end else begin
      nvm_rsp.valid <= 1'b0;
      nvm_rsp.data  <= ~nvm_rsp.data;
      wait_cnt      <= (nvm_req.req || busy) ? wait_cnt + 2'h1 : 2'h0;
      busy          <= nvm_req.req || busy;
    end
  end
endmodule : fsi_nvm_model

// ### bench/tb_fsi_core.sv
// Purpose: Self-checking bench for the flash security and irq block.
// Assumes: 10 MHz clock; array model answers the load reads.
// Notes:   Command register write is held high so its accept shows.
`timescale 1ns/100ps
module tb_fsi_core;
  import fsi_pkg::*;
  localparam logic [63:0] KEYS = 64'h4444_3333_2222_1111;
  localparam fsi_cfg_t    CFG_A = 32'hBF5A3C77;
  logic         clk, rst, launch, done, kv, ev_ok, ssc, wr, stop_req;
  logic         cc_en, df_en, sf_en, df, sf, wait_m, slow, fault;
  logic [63:0]  key_p, m_keys;
  logic [15:0]  rd_data, rd_out;
  logic         flag, wr_ok, abort, stall, rd_inv, stop_ack, cmd_irq;
  logic         err_irq, kv_ok, kv_fail, lockout;
  logic [1:0]   vfs;
  fsi_cfg_t     cfg, m_cfg;
  fsi_nvm_req_t nvm_req;
  fsi_nvm_rsp_t nvm_rsp;
  int           n_fail, checked, n;

  fsi_core i_fsi_core (.clk(clk), .rst(rst), .nvm_req(nvm_req),
    .nvm_rsp(nvm_rsp), .cmd_launch(launch), .cmd_done(done),
    .cmd_is_keyverify(kv), .key_presented(key_p),
    .erase_verify_all_ok(ev_ok), .special_single_chip(ssc),
    .command_complete_irq_enable(cc_en), .double_fault_irq_enable(df_en),
    .single_fault_irq_enable(sf_en), .double_fault_flag(df),
    .single_fault_flag(sf), .cmd_reg_write(wr), .block0_read_data(rd_data),
    .stop_request(stop_req), .wait_mode(wait_m),
    .command_complete_flag(flag), .cmd_reg_write_ok(wr_ok),
    .cmd_abort(abort), .cpu_stall(stall), .block0_read_out(rd_out),
    .block0_read_invalid(rd_inv), .stop_ack(stop_ack), .cmd_irq(cmd_irq),
    .err_irq(err_irq), .keyverify_ok(kv_ok), .keyverify_fail(kv_fail),
    .key_lockout(lockout), .verify_fault_status(vfs), .cfg(cfg));

  fsi_nvm_model i_fsi_nvm_model (.clk(clk), .rst(rst), .nvm_req(nvm_req),
    .nvm_rsp(nvm_rsp), .cfg_bytes(m_cfg), .keys(m_keys), .slow(slow),
    .fault(fault));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Reset, watch the stall and load phases, then check loaded values
  task automatic do_reset(input fsi_cfg_t c, input logic [63:0] k,
                          input logic f);
    @(posedge clk);
    m_cfg  <= c;
    m_keys <= k;
    fault  <= f;
    rst    <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk({flag, stall, abort, lockout, wr_ok}, 5'h0C);
    @(posedge clk);
    rst <= 1'b0;
    #1;
    for (n = 0; n < 50 && stall === 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({stall, flag, wr_ok}, 3'h0);
    chk(n, FSI_STALL_CYC);
    for (n = 0; n < 99 && flag !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({flag, wr_ok}, 2'h3);
    chk(cfg, f ? {FSI_SEC_DEFAULT, FSI_PPROT_DEFAULT, FSI_DPROT_DEFAULT,
                  FSI_OPT_DEFAULT} : c);
    chk(vfs, f ? 2'h3 : 2'h0);
  endtask : do_reset

  // Key verify with stop requested while it runs
  task automatic run_cmd(input logic [63:0] k, input logic ok);
    @(posedge clk);
    launch   <= 1'b1;
    kv       <= 1'b1;
    key_p    <= k;
    stop_req <= 1'b1;
    @(posedge clk);
    launch <= 1'b0;
    #1;
    chk({flag, stop_ack, cmd_irq, wr_ok, rd_inv, rd_out},
        {5'h01, FSI_BAD_READ_DATA});
    @(posedge clk);
    done <= 1'b1;
    #1;
    chk({rd_inv, rd_out}, {1'b1, FSI_BAD_READ_DATA});
    @(posedge clk);
    done <= 1'b0;
    #1;
    chk({flag, kv_ok, kv_fail, stop_ack}, {1'b1, ok, !ok, 1'b1});
    chk(cfg, {m_cfg[31:26], ok ? FSI_SEC_UNSECURED : m_cfg[25:24],
              m_cfg[23:0]});
    @(posedge clk);
    stop_req <= 1'b0;
  endtask : run_cmd

  // Every enable and fault flag combination, complete flag set, wait mode held on
  task automatic irq_scan();
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      {wait_m, cc_en, df_en, sf_en, df, sf} <= {1'b1, 5'(i)};
      @(posedge clk);
      #1;
      chk({cmd_irq, err_irq}, {i[4], (i[3] & i[1]) | (i[2] & i[0])});
    end
    @(posedge clk);
    {df, sf} <= 2'h0;
  endtask : irq_scan

  // Erase verify pass in special single chip mode
  task automatic erase_unsec();
    @(posedge clk);
    ssc   <= 1'b1;
    ev_ok <= 1'b1;
    @(posedge clk);
    ssc   <= 1'b0;
    ev_ok <= 1'b0;
    @(posedge clk);
    #1;
    chk(cfg.security_register[1:0], FSI_SEC_UNSECURED);
  endtask : erase_unsec

  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {launch, done, kv, ev_ok, ssc, stop_req, cc_en, df_en} = '0;
    {sf_en, df, sf, wait_m, fault, key_p} = '0;
    {rst, wr, slow} = 3'h7;
    rd_data = 16'h1234;
    m_keys  = KEYS;
    m_cfg   = CFG_A;
    do_reset(CFG_A, KEYS, 1'b0);
    irq_scan();
    run_cmd(KEYS ^ 64'h1, 1'b0);
    run_cmd(KEYS, 1'b0);
    chk(lockout, 1'b1);
    do_reset(CFG_A, KEYS, 1'b0);
    run_cmd(KEYS, 1'b1);
    do_reset(32'hFF5A3C77, KEYS, 1'b0);
    run_cmd(KEYS, 1'b0);
    do_reset(CFG_A, 64'h4444_3333_2222_0000, 1'b0);
    run_cmd(64'h4444_3333_2222_0000, 1'b0);
    erase_unsec();
    do_reset(CFG_A, KEYS, 1'b1);
    report_and_stop();
  end
endmodule : tb_fsi_core
